// ### hw/uhs_host_seq.sv
// uhs_host_seq: channel-zero transaction engine with automatic control
// stage sequencing, split and preamble handling, AHB-Lite registers.
// Assumes one downstream partner on uhs_link_if that answers each request.
`timescale 1ns/1ps
module uhs_host_seq
  import uhs_pkg::*;
#(
  parameter int MAXPKT   = 64,
  parameter int FIFO_CAP = 512
)
(
  input  wire logic        hclk,      // system clock
  input  wire logic        hresetn,   // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic [2:0]  hsize,     // word only
  input  wire logic [31:0] hwdata,    // write data
  input  wire logic        hready,    // bus ready
  output logic             hreadyout, // slave ready
  output logic [31:0]      hrdata,    // read data
  output logic             hresp,     // always OKAY
  uhs_link_if.host         link       // downstream link
);
  localparam logic [15:0] MPK = 16'(MAXPKT);
  localparam logic [15:0] CAP = 16'(FIFO_CAP);

  typedef enum logic [6:0] {S_IDLE = 7'h01, S_ISSUE = 7'h02,
    S_WAIT = 7'h04, S_HSK = 7'h08, S_DONE = 7'h10, S_ABORT = 7'h20,
    S_STOP = 7'h40} uhs_state_t;

  uhs_state_t  state_ff, nxt_state;
  logic        hready_ff, rd_pend_ff, wr_pend_ff;
  logic [7:0]  addr_ff;
  logic [31:0] hrdata_ff;
  logic        go_ff, seq_go_ff, iso_ff, tog_ff, cs_ff;
  logic [1:0]  tt_ff, spd_ff, topo_ff, stage_ff, errcnt_ff, ttl_ff;
  logic [6:0]  hub_addr_ff, hub_port_ff;
  logic [63:0] setup_ff;
  logic [15:0] count_ff, level_ff, len_ff, rlen_ff;
  logic [4:0]  flags_ff;
  logic [3:0]  code_ff;

  // bus decode; reads take one wait state so hrdata comes from a flop
  wire addr_ok  = hsel & htrans[1] & hready;
  wire wr_ctrl  = wr_pend_ff & (addr_ff == ADDR_CTRL);
  wire wr_hub   = wr_pend_ff & (addr_ff == ADDR_HUB);
  wire wr_su_lo = wr_pend_ff & (addr_ff == ADDR_SETUP_LO);
  wire wr_su_hi = wr_pend_ff & (addr_ff == ADDR_SETUP_HI);
  wire wr_count = wr_pend_ff & (addr_ff == ADDR_COUNT);
  wire wr_fifo  = wr_pend_ff & (addr_ff == ADDR_FIFO);
  wire wr_stat  = wr_pend_ff & (addr_ff == ADDR_STAT);
  wire [31:0] ctrl_rd = {20'h0, tog_ff, stage_ff, seq_go_ff, iso_ff,
                         topo_ff, spd_ff, tt_ff, go_ff};
  wire [31:0] rd_mux =
    (addr_ff == ADDR_CTRL)     ? ctrl_rd :
    (addr_ff == ADDR_HUB)      ? {17'h0, hub_port_ff, 1'h0, hub_addr_ff} :
    (addr_ff == ADDR_SETUP_LO) ? setup_ff[31:0] :
    (addr_ff == ADDR_SETUP_HI) ? setup_ff[63:32] :
    (addr_ff == ADDR_COUNT)    ? {16'h0, count_ff} :
    (addr_ff == ADDR_FIFO)     ? {16'h0, level_ff} :
    (addr_ff == ADDR_STAT)     ? {20'h0, code_ff, 3'h0, flags_ff} : 32'h0;

  // what the next transaction is; stage drives it while sequencing
  wire        in_dir   = setup_ff[7];
  wire [15:0] wlen     = setup_ff[63:48];
  wire        has_data = (wlen != 16'h0000);
  wire        is_stat  = seq_go_ff & (stage_ff == ST_STATUS);
  wire [1:0]  cur_tt   =
    !seq_go_ff                ? tt_ff :
    (stage_ff == ST_SETUP)    ? TT_SETUP :
    (stage_ff == ST_DATA)     ? (in_dir ? TT_IN : TT_OUT) :
    (in_dir & has_data)       ? TT_OUT : TT_IN;
  wire [15:0] free     = CAP - level_ff;
  wire [15:0] lim      = (count_ff < MPK) ? count_ff : MPK;
  wire [15:0] out_len  = (lim < level_ff) ? lim : level_ff;
  wire [15:0] cur_len  =
    (cur_tt == TT_SETUP) ? SETUP_LEN :
    is_stat              ? 16'h0000 :
    (cur_tt == TT_OUT)   ? out_len : lim;
  // data stage stalls on empty FIFO (OUT) or less than MPK free (IN); status OUT waits for drain
  wire can_issue = !seq_go_ff ? go_ff :
    (stage_ff == ST_DATA) ? (in_dir ? (free >= MPK)
                                    : (level_ff != 16'h0000)) :
    (is_stat & in_dir & has_data) ? (level_ff == 16'h0000) :
    (stage_ff != ST_IDLE);
  wire use_split = (topo_ff == TOPO_HS_HUB) & (spd_ff != SPD_HS);
  wire iso_out   = iso_ff & (ttl_ff == TT_OUT);
  wire rsp_ok    = link.rsp_valid & (link.rsp_code == RSP_ACK);
  wire rsp_err   = link.rsp_valid & (link.rsp_code == RSP_ERR);
  wire in_pre    = (spd_ff == SPD_LS) & (topo_ff == TOPO_FS_HUB);
  wire [15:0] moved   = (ttl_ff == TT_IN) ? rlen_ff : len_ff;
  wire [15:0] new_cnt = count_ff - moved;
  wire        short   = (ttl_ff == TT_IN) & (rlen_ff < len_ff);
  wire        seq_new = seq_go_ff & (stage_ff == ST_IDLE);
  // hardware events; a set beats a same-cycle firmware clear
  wire [4:0] set_flags = {state_ff == S_STOP,
                          (state_ff == S_DONE) & is_stat,
                          state_ff == S_ABORT,
                          (state_ff == S_WAIT) & rsp_err,
                          state_ff == S_DONE};
  wire [4:0] nxt_flags = (flags_ff & ~({5{wr_stat}} & hwdata[4:0]))
                         | set_flags;

  // sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:  if (can_issue & !seq_new) nxt_state = S_ISSUE;
      S_ISSUE: nxt_state = S_WAIT;
      S_WAIT:
        if (rsp_err)
          nxt_state = (errcnt_ff == ERR_LAST & !iso_ff) ? S_ABORT
                                                       : S_IDLE;
        else if (rsp_ok & use_split & !cs_ff & !iso_out)
          nxt_state = S_ISSUE;                 // go on to complete-split
        else if (rsp_ok & (ttl_ff == TT_IN) & !use_split)
          nxt_state = S_HSK;
        else if (rsp_ok)
          nxt_state = S_DONE;
        else if (link.rsp_valid)
          nxt_state = S_IDLE;                  // NAK: try again later
      S_HSK:   nxt_state = S_DONE;
      S_DONE:  nxt_state = S_IDLE;
      S_ABORT: nxt_state = seq_go_ff ? S_STOP : S_IDLE;
      S_STOP:  nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // bus slave flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hready_ff  <= 1'b1;
      rd_pend_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
      hrdata_ff  <= 32'h0;
    end
    else
    begin
      hready_ff  <= ~(addr_ok & ~hwrite);
      rd_pend_ff <= addr_ok & ~hwrite;
      wr_pend_ff <= addr_ok & hwrite;
      if (addr_ok)
        addr_ff <= haddr[7:0];
      if (rd_pend_ff)
        hrdata_ff <= rd_mux;
    end
  end

  // firmware configuration and the status flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      spd_ff      <= SPD_HS;
      topo_ff     <= TOPO_DIRECT;
      iso_ff      <= 1'b0;
      hub_addr_ff <= 7'h00;
      hub_port_ff <= 7'h00;
      setup_ff    <= 64'h0;
      flags_ff    <= 5'h00;
    end
    else
    begin
      flags_ff <= nxt_flags;
      if (wr_ctrl)
      begin
        spd_ff  <= hwdata[B_SPD +: 2];
        topo_ff <= hwdata[B_TOPO +: 2];
        iso_ff  <= hwdata[B_ISO];
      end
      if (wr_hub)
      begin
        hub_addr_ff <= hwdata[6:0];
        hub_port_ff <= hwdata[B_PORT +: 7];
      end
      if (wr_su_lo)
        setup_ff[31:0] <= hwdata;
      if (wr_su_hi)
        setup_ff[63:32] <= hwdata;
    end
  end

  // engine: channel zero is the only channel, so it carries the sequencer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff  <= S_IDLE;
      go_ff     <= 1'b0;
      seq_go_ff <= 1'b0;
      tt_ff     <= TT_SETUP;
      stage_ff  <= ST_IDLE;
      tog_ff    <= 1'b0;
      cs_ff     <= 1'b0;
      errcnt_ff <= 2'h0;
      ttl_ff    <= TT_SETUP;
      count_ff  <= 16'h0000;
      level_ff  <= 16'h0000;
      len_ff    <= 16'h0000;
      rlen_ff   <= 16'h0000;
      code_ff   <= CC_OK;
    end
    else
    begin
      state_ff <= nxt_state;
      // fifo deltas from firmware plus the hardware update on success
      level_ff <= level_ff
        + (wr_fifo ? hwdata[15:0] : 16'h0000)
        - (wr_fifo ? hwdata[B_POP +: 16] : 16'h0000)
        + ((state_ff == S_DONE & ttl_ff == TT_IN) ? rlen_ff : 16'h0000)
        - ((state_ff == S_DONE & ttl_ff == TT_OUT) ? len_ff : 16'h0000);
      // hardware owns go, type and count while sequencing
      if (wr_ctrl & !seq_go_ff)
      begin
        go_ff <= hwdata[B_GO];
        tt_ff <= hwdata[B_TT +: 2];
      end
      if (wr_ctrl)
      begin
        seq_go_ff <= hwdata[B_SEQ_GO];
        stage_ff  <= hwdata[B_STAGE +: 2];
      end
      if (wr_count & !seq_go_ff)
        count_ff <= hwdata[15:0];
      case (state_ff)
        S_IDLE:
          if (seq_new & !wr_ctrl)
          begin
            stage_ff  <= ST_SETUP;
            errcnt_ff <= 2'h0;
          end
        S_ISSUE:
        begin
          ttl_ff <= cur_tt;
          len_ff <= cur_len;
        end
        S_WAIT:
          if (rsp_err)
          begin
            code_ff   <= CC_RETRY;
            errcnt_ff <= errcnt_ff + 2'h1;
            cs_ff     <= 1'b0;            // retry from start-split
          end
          else if (rsp_ok & use_split & !cs_ff & !iso_out)
            cs_ff <= 1'b1;                // silent step
          else if (rsp_ok)
          begin
            rlen_ff   <= link.rsp_len;
            errcnt_ff <= 2'h0;
            cs_ff     <= 1'b0;
          end
        S_DONE:
        begin
          code_ff <= CC_OK;
          tog_ff  <= ~tog_ff;
          if (ttl_ff != TT_SETUP)
            count_ff <= new_cnt;
          if (!seq_go_ff & (new_cnt == 16'h0000 | short))
            go_ff <= 1'b0;
          else if (seq_go_ff)
            case (stage_ff)
              ST_SETUP:
              begin
                tog_ff   <= 1'b1;
                count_ff <= wlen;
                stage_ff <= has_data ? ST_DATA : ST_STATUS;
              end
              ST_DATA:
                if (new_cnt == 16'h0000 | short)
                begin
                  stage_ff <= ST_STATUS;
                  tog_ff   <= 1'b1;
                end
              default:
              begin
                seq_go_ff <= 1'b0;
                stage_ff  <= ST_IDLE;
              end
            endcase
        end
        S_ABORT:
        begin
          go_ff     <= 1'b0;
          seq_go_ff <= 1'b0;              // stage kept
          errcnt_ff <= 2'h0;
        end
        default: ;
      endcase
    end
  end

  // link request and handshake flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.req_valid    <= 1'b0;
      link.req_kind     <= TT_SETUP;
      link.req_split    <= SPL_NONE;
      link.req_pre      <= 1'b0;
      link.req_ls       <= 1'b0;
      link.req_tog      <= 1'b0;
      link.req_len      <= 16'h0000;
      link.req_hub_addr <= 7'h00;
      link.req_hub_port <= 7'h00;
      link.req_setup    <= 64'h0;
      link.hs_valid     <= 1'b0;
      link.hs_pre       <= 1'b0;
    end
    else
    begin
      link.req_valid <= (state_ff == S_ISSUE);
      link.hs_valid  <= (state_ff == S_HSK);
      link.hs_pre    <= (state_ff == S_HSK) & in_pre;
      if (state_ff == S_ISSUE)
      begin
        link.req_kind     <= cur_tt;
        link.req_split    <= !use_split ? SPL_NONE :
                             cs_ff ? SPL_COMPLETE : SPL_START;
        link.req_pre      <= in_pre;
        link.req_ls       <= (spd_ff == SPD_LS) &
                             (topo_ff != TOPO_HS_HUB);
        link.req_tog      <= tog_ff;
        link.req_len      <= cur_len;
        link.req_hub_addr <= hub_addr_ff;
        link.req_hub_port <= hub_port_ff;
        link.req_setup    <= setup_ff;
      end
    end
  end

  assign hreadyout = hready_ff;
  assign hrdata    = hrdata_ff;
  assign hresp     = 1'b0;
endmodule

// ### hw/uhs_hub_dev.sv
// uhs_hub_dev: downstream end answering the host sequencer: a hub that
// accepts splits plus the endpoint behind it, with a chosen outcome.
// Assumes requests arrive one at a time, spaced by the answer.
`timescale 1ns/1ps
module uhs_hub_dev
  import uhs_pkg::*;
(
  input  wire logic        hclk,        // system clock
  input  wire logic        hresetn,     // async reset, active low
  uhs_link_if.hub          link,        // downstream link
  input  wire logic [1:0]  fault_sel,   // answer code for each request
  input  wire logic [15:0] in_bytes,    // bytes an IN returns
  output logic [63:0]      setup_seen,  // last setup bytes received
  output logic             pre_seen,    // last request had preamble
  output logic             ls_seen,     // last request at low speed
  output logic [1:0]       split_seen,  // last split kind
  output logic             hs_pre_seen, // last handshake had preamble
  output logic [15:0]      xact_cnt     // requests received
);
  localparam logic [3:0] LAT = 4'(RSP_LAT_CYC);

  logic [3:0]  wait_ff;
  logic        pend_ff;
  logic [15:0] len_ff;
  logic        in_ff, ss_ff;
  logic [63:0] setup_ff;
  logic        pre_ff, ls_ff, hs_pre_ff;
  logic [1:0]  split_ff;
  logic [15:0] cnt_ff;

  // an IN returns the smaller of what is offered and what is expected
  wire [15:0] ret_len = (in_bytes < len_ff) ? in_bytes : len_ff;

  // answer a request after a fixed delay
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_ff         <= 4'h0;
      pend_ff         <= 1'b0;
      len_ff          <= 16'h0000;
      in_ff           <= 1'b0;
      ss_ff           <= 1'b0;
      link.rsp_valid  <= 1'b0;
      link.rsp_code   <= RSP_ACK;
      link.rsp_len    <= 16'h0000;
    end
    else
    begin
      link.rsp_valid <= 1'b0;
      if (link.req_valid)
      begin
        pend_ff <= 1'b1;
        wait_ff <= LAT;
        len_ff  <= link.req_len;
        in_ff   <= (link.req_kind == TT_IN);
        ss_ff   <= (link.req_split == SPL_START);
      end
      else if (pend_ff & wait_ff != 4'h0)
        wait_ff <= wait_ff - 4'h1;
      else if (pend_ff)
      begin
        // a start-split carries no IN data back
        pend_ff        <= 1'b0;
        link.rsp_valid <= 1'b1;
        link.rsp_code  <= fault_sel;
        link.rsp_len   <= (in_ff & !ss_ff) ? ret_len : 16'h0000;
      end
    end
  end

  // observation of what the host sent
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      setup_ff  <= 64'h0;
      pre_ff    <= 1'b0;
      ls_ff     <= 1'b0;
      split_ff  <= SPL_NONE;
      hs_pre_ff <= 1'b0;
      cnt_ff    <= 16'h0000;
    end
    else
    begin
      if (link.req_valid)
      begin
        pre_ff   <= link.req_pre;
        ls_ff    <= link.req_ls;
        split_ff <= link.req_split;
        cnt_ff   <= cnt_ff + 16'h0001;
      end
      if (link.req_valid & link.req_kind == TT_SETUP)
        setup_ff <= link.req_setup;
      if (link.hs_valid)
        hs_pre_ff <= link.hs_pre;
    end
  end

  assign setup_seen  = setup_ff;
  assign pre_seen    = pre_ff;
  assign ls_seen     = ls_ff;
  assign split_seen  = split_ff;
  assign hs_pre_seen = hs_pre_ff;
  assign xact_cnt    = cnt_ff;
endmodule

// ### inc/uhs_link_if.sv
// uhs_link_if: transaction-level downstream link between the host
// sequencer and the hub/device end. Both ends share hclk and hresetn.
`timescale 1ns/1ps
interface uhs_link_if
(
  input wire logic hclk,   // common clock
  input wire logic hresetn // async reset, active low
);
  logic        req_valid;     // one-cycle transaction request
  logic [1:0]  req_kind;      // SETUP, OUT or IN
  logic [1:0]  req_split;     // none, start-split, complete-split
  logic        req_pre;       // packets preceded by a preamble
  logic        req_ls;        // packet sent at low-speed bit time
  logic        req_tog;       // data toggle
  logic [15:0] req_len;       // bytes sent (OUT) or expected (IN)
  logic [6:0]  req_hub_addr;  // translating hub address
  logic [6:0]  req_hub_port;  // translating hub port
  logic [63:0] req_setup;     // setup bytes, byte 0 in bits 7:0
  logic        hs_valid;      // host handshake after IN data
  logic        hs_pre;        // that handshake carries a preamble
  logic        rsp_valid;     // one-cycle answer
  logic [1:0]  rsp_code;      // ACK, NAK or error
  logic [15:0] rsp_len;       // bytes returned for IN

  modport host (output req_valid, req_kind, req_split, req_pre, req_ls,
                req_tog, req_len, req_hub_addr, req_hub_port, req_setup,
                hs_valid, hs_pre, input rsp_valid, rsp_code, rsp_len);
  modport hub (input req_valid, req_kind, req_split, req_pre, req_ls,
               req_tog, req_len, req_hub_addr, req_hub_port, req_setup,
               hs_valid, hs_pre, output rsp_valid, rsp_code, rsp_len);
endinterface

// ### inc/uhs_pkg.sv
// uhs_pkg: shared constants and types for the channel-zero host sequencer
// and the downstream hub/device end that answers it over uhs_link_if.
// Assumes a single 10 MHz clock and an AHB-Lite register window.
// Functional notes
// - direct low-speed device uses low-speed bit time
// - full-speed hub: preamble before every low-speed packet
// - low-speed IN via hub: ACK sent with preamble
// - high-speed hub: full/low speed uses split transactions
// - firmware programs hub address and port first
// - hardware runs whole start-to-complete split series
// - final complete-split success: ack flag, FIFO update
// - isochronous OUT: final start-split acks; others silent
// - split step error: retry code, error flag, retry
// - three split errors: clear go, condition changed; with iso set the code never aborts and retries without limit
// - manual status stage: firmware sets byte count zero
// - automatic stage sequencing exists on channel zero only
// - eight setup bytes sent unchanged in SETUP
// - firmware starts sequence with go and idle stage
// - request bit7 clear: OUT data until wLength sent
// - bit7 set: IN data until wLength or short
// - wLength zero skips data stage
// - stall OUT on empty FIFO, IN on full; the code stalls IN whenever less than MPK is free
// - status IN after OUT; OUT after FIFO drained
// - normal end clears sequence go, sets complete flag
// - error aborts: keep stage, code, changed, then stopped
// - resume keeps stage; new transfer writes idle first
// - firmware keeps off hardware-owned fields while sequencing
package uhs_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_HUB      = 8'h04;
  localparam logic [7:0] ADDR_SETUP_LO = 8'h08;
  localparam logic [7:0] ADDR_SETUP_HI = 8'h0C;
  localparam logic [7:0] ADDR_COUNT    = 8'h10;
  localparam logic [7:0] ADDR_FIFO     = 8'h14;
  localparam logic [7:0] ADDR_STAT     = 8'h18;

  // register field positions: control, hub, fifo and status
  localparam int B_GO     = 0;
  localparam int B_TT     = 1;
  localparam int B_SPD    = 3;
  localparam int B_TOPO   = 5;
  localparam int B_ISO    = 7;
  localparam int B_SEQ_GO = 8;
  localparam int B_STAGE  = 9;
  localparam int B_TOG    = 11;
  localparam int B_PORT   = 8;
  localparam int B_POP    = 16;
  localparam int B_CODE   = 8;

  typedef enum logic [1:0] {TT_SETUP = 2'h0, TT_OUT = 2'h1,
                            TT_IN = 2'h2} uhs_tt_t;
  typedef enum logic [1:0] {SPD_HS = 2'h0, SPD_FS = 2'h1,
                            SPD_LS = 2'h2} uhs_spd_t;
  typedef enum logic [1:0] {TOPO_DIRECT = 2'h0, TOPO_FS_HUB = 2'h1,
                            TOPO_HS_HUB = 2'h2} uhs_topo_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_SETUP = 2'h1,
                            ST_DATA = 2'h2, ST_STATUS = 2'h3} uhs_stage_t;
  typedef enum logic [1:0] {SPL_NONE = 2'h0, SPL_START = 2'h1,
                            SPL_COMPLETE = 2'h2} uhs_split_t;
  typedef enum logic [1:0] {RSP_ACK = 2'h0, RSP_NAK = 2'h1,
                            RSP_ERR = 2'h2} uhs_rsp_t;

  // result codes
  localparam logic [3:0] CC_OK    = 4'h0;
  localparam logic [3:0] CC_RETRY = 4'h1;

  localparam logic [1:0]  ERR_LAST  = 2'h2;   // third error in a row
  localparam logic [15:0] SETUP_LEN = 16'h0008;

  // far-end answer delay
  localparam int RSP_LAT_NS  = 300;
  localparam int CLK_NS      = 100;
  localparam int RSP_LAT_CYC = RSP_LAT_NS / CLK_NS;

endpackage

// ### tb/uhs_chk.sv
// uhs_chk: link protocol assertions between host sequencer and hub end.
// Assumes plain inputs wired from uhs_link_if in the bench top.
`timescale 1ns/1ps
module uhs_chk
  import uhs_pkg::*;
(
  input wire logic        hclk,      // clock
  input wire logic        hresetn,   // reset, low
  input wire logic        req_valid, // request pulse
  input wire logic [1:0]  req_kind,  // kind
  input wire logic [1:0]  req_split, // split kind
  input wire logic        req_pre,   // preamble
  input wire logic        req_ls,    // low-speed bit time
  input wire logic [15:0] req_len,   // length
  input wire logic        hs_valid,  // host handshake
  input wire logic        hs_pre,    // handshake preamble
  input wire logic        rsp_valid  // answer pulse
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // answer timing and one request in flight
  chk_rsp_latency:
    assert property (req_valid |-> ##5 rsp_valid) else $error("late answer");
  chk_one_outstanding:
    assert property (req_valid |=> !req_valid [*5]) else $error("overlap");
  chk_req_gap:
    assert property (rsp_valid |-> !req_valid ##1 !req_valid)
    else $error("request too soon");
  // packet shape: setup length, preamble speed, split port speed
  chk_setup_len:
    assert property (req_valid && req_kind == TT_SETUP
                     |-> req_len == SETUP_LEN)
    else $error("setup length");
  chk_pre_ls:
    assert property (req_valid && req_pre |-> req_ls) else $error("pre speed");
  chk_split_hs:
    assert property (req_valid && req_split != SPL_NONE
                     |-> !req_pre && !req_ls)
    else $error("split not at high speed");
  chk_hs_pre_in:
    assert property (hs_valid |-> req_kind == TT_IN && hs_pre == req_pre)
    else $error("handshake preamble");
  chk_hs_nosplit:
    assert property (hs_valid |-> req_split == SPL_NONE && !$past(req_valid))
    else $error("handshake on split");
  // main scenarios reached
  cov_setup: cover property (req_valid && req_kind == TT_SETUP);
  cov_split: cover property (req_valid && req_split == SPL_COMPLETE);
  cov_pre_hs: cover property (hs_valid && hs_pre);
endmodule

// ### tb/uhs_tb_top.sv
// uhs_tb_top: host sequencer and hub end joined over uhs_link_if.
// Assumes AHB-Lite single word transfers and a 10 MHz clock.
`timescale 1ns/1ps
module uhs_tb_top
  import uhs_pkg::*;
;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout;
  logic        hresp, pre_s, ls_s, hsp_s;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0, fault_sel = 0, split_s;
  logic [63:0] setup_s;
  logic [15:0] xcnt, n0;
  int          err_total = 0, checks = 0;
  always #50 hclk = ~hclk;
  uhs_link_if lk (.hclk(hclk), .hresetn(hresetn));
  uhs_host_seq i_uhs_host_seq (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(lk.host));
  uhs_hub_dev i_uhs_hub_dev (.hclk(hclk), .hresetn(hresetn), .link(lk.hub),
    .fault_sel(fault_sel), .in_bytes(16'h0008), .setup_seen(setup_s),
    .pre_seen(pre_s), .ls_seen(ls_s), .split_seen(split_s),
    .hs_pre_seen(hsp_s), .xact_cnt(xcnt));
  uhs_chk i_uhs_chk (.hclk(hclk), .hresetn(hresetn),
    .req_valid(lk.req_valid), .req_kind(lk.req_kind),
    .req_split(lk.req_split), .req_pre(lk.req_pre), .req_ls(lk.req_ls),
    .req_len(lk.req_len), .hs_valid(lk.hs_valid), .hs_pre(lk.hs_pre),
    .rsp_valid(lk.rsp_valid));
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  // one single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w)
      rd = hrdata;
  endtask
  // poll status until flag b rises, bounded by the watchdog
  task automatic wait_flag(input int b);
    do bus(1'b0, ADDR_STAT, 32'h0); while (rd[b] !== 1'b1);
  endtask
  // load setup bytes, start the sequence with idle stage
  task automatic start(input logic [31:0] lo, input logic [31:0] hi,
                       input logic [31:0] ctl);
    bus(1'b1, ADDR_SETUP_LO, lo);
    bus(1'b1, ADDR_SETUP_HI, hi);
    n0 = xcnt;
    bus(1'b1, ADDR_CTRL, ctl | 32'h0000_0100);
  endtask
  // no data stage, one speed and topology setting per call
  task automatic t_cfg(input logic [31:0] ctl, input logic pr, input logic ls,
                       input logic [1:0] sp, input logic [15:0] n);
    start(32'h0000_0500, 32'h0, ctl);
    wait_flag(3);
    chk(rd[1:0], 2'b01);
    chk(setup_s, 64'h0000_0000_0000_0500);
    chk(xcnt - n0, n);
    chk({pre_s, ls_s, split_s}, {pr, ls, sp});
    if (sp == SPL_NONE)
      chk(hsp_s, pr);
    bus(1'b1, ADDR_STAT, 32'h1F);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[10:8], 3'b000);
    $display("test cfg %h done", ctl);
  endtask
  // three errors abort the setup stage, then resume from it
  task automatic t_abort;
    fault_sel <= RSP_ERR;
    start(32'h0000_0500, 32'h0, 32'h0);
    wait_flag(4);
    chk({rd[11:8], rd[2:1]}, {CC_RETRY, 2'b11});
    chk(xcnt - n0, 16'h3);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[10:8], {ST_SETUP, 1'b0});
    fault_sel <= RSP_ACK;
    bus(1'b1, ADDR_STAT, 32'h1F);
    bus(1'b1, ADDR_CTRL, 32'h0000_0300);
    wait_flag(3);
    chk(rd[4], 1'b0);
    bus(1'b1, ADDR_STAT, 32'h1F);
    $display("test abort done");
  endtask
  // OUT data stage of four bytes stalls until the fifo is filled
  task automatic t_out;
    start(32'h0000_0500, 32'h0004_0000, 32'h0);
    repeat (60) @(posedge hclk); // long enough for several answers
    chk(xcnt - n0, 16'h1);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[10:9], ST_DATA);
    bus(1'b1, ADDR_FIFO, 32'h0000_0004);
    wait_flag(3);
    chk(xcnt - n0, 16'h3);
    bus(1'b1, ADDR_STAT, 32'h1F);
    $display("test out done");
  endtask
  // IN data stage cut short by the device; status OUT waits for a drain
  task automatic t_in;
    start(32'h0000_0580, 32'h0010_0000, 32'h0);
    repeat (60) @(posedge hclk); // status OUT must not start yet
    chk(xcnt - n0, 16'h2);
    bus(1'b0, ADDR_FIFO, 32'h0);
    chk(rd, 32'h0000_0008);
    bus(1'b1, ADDR_FIFO, 32'h0008_0000);
    wait_flag(3);
    chk(xcnt - n0, 16'h3);
    bus(1'b1, ADDR_STAT, 32'h1F);
    $display("test in done");
  endtask
  // one manual transaction with a zero byte count, no sequencing
  task automatic t_man(input logic [31:0] ctl, input logic [1:0] sp);
    bus(1'b1, ADDR_COUNT, 32'h0);
    n0 = xcnt;
    bus(1'b1, ADDR_CTRL, ctl);
    wait_flag(0);
    chk(xcnt - n0, 16'h1);
    chk(split_s, sp);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk({rd[8], rd[0]}, 2'b00);
    bus(1'b1, ADDR_STAT, 32'h1F);
    $display("test man %h done", ctl);
  endtask
  task automatic complete_run;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_cfg(32'h00, 1'b0, 1'b0, SPL_NONE, 16'h2);
    t_cfg(32'h10, 1'b0, 1'b1, SPL_NONE, 16'h2);
    t_cfg(32'h30, 1'b1, 1'b1, SPL_NONE, 16'h2);
    bus(1'b1, ADDR_HUB, 32'h0000_0312);
    bus(1'b0, ADDR_HUB, 32'h0);
    chk(rd, 32'h0000_0312);
    t_cfg(32'h50, 1'b0, 1'b0, SPL_COMPLETE, 16'h4);
    t_abort;
    t_out;
    t_in;
    t_man(32'h05, SPL_NONE);
    t_man(32'hCB, SPL_START);
    complete_run;
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    complete_run;
  end
endmodule
